// ===== rtl/iofd_consts.svh
// Purpose: shared constants of the integer opcode field decoder
// Assumes: included by the package, the field decoder and the top module; 32-bit AXI4-Lite data
// Notes: field codes, group codes, register offsets and reset values
`ifndef IOFD_CONSTS_SVH
`define IOFD_CONSTS_SVH

// ----------------------------------------------------------------
// Opcode word fields
// ----------------------------------------------------------------
`define IOFD_GRP_QUICK 4'h5
`define IOFD_GRP_BRANCH 4'h6
`define IOFD_GRP_QMOVE 4'h7
`define IOFD_GRP_OR 4'h8
`define IOFD_GRP_SUB 4'h9
`define IOFD_GRP_CMP 4'hb
`define IOFD_GRP_AND 4'hc
`define IOFD_SZ_BYTE 2'h0
`define IOFD_SZ_WORD 2'h1
`define IOFD_SZ_LONG 2'h2
`define IOFD_SZ_NONE 2'h3
`define IOFD_TRAP_WORD 3'h2
`define IOFD_TRAP_LONG 3'h3
`define IOFD_TRAP_NONE 3'h4
`define IOFD_QUICK_EIGHT 4'h8
`define IOFD_DISP_WORD 8'h00
`define IOFD_DISP_LONG 8'hff
`define IOFD_COND_TRUE 4'h0
`define IOFD_COND_SUBR 4'h1
`define IOFD_EA_AREG 3'h1
`define IOFD_EA_SPECIAL 3'h7
`define IOFD_DSUB_FORM 5'h10
`define IOFD_OPM_DIVU 3'h3
`define IOFD_OPM_DIVS 3'h7

// ----------------------------------------------------------------
// Register map and bus answers
// ----------------------------------------------------------------
`define IOFD_ADDR_W 8
`define IOFD_REG_CTRL 8'h00
`define IOFD_REG_STATUS 8'h04
`define IOFD_REG_OPWORD 8'h08
`define IOFD_REG_EXT 8'h0c
`define IOFD_REG_IMM 8'h10
`define IOFD_REG_COUNT 8'h14
`define IOFD_CTRL_RESET 32'h0000_0001
`define IOFD_CTRL_EN_BIT 0
`define IOFD_CTRL_CLR_BIT 1
`define IOFD_RESP_OKAY 2'h0
`define IOFD_RESP_SLVERR 2'h2

`endif

// ===== rtl/iofd_pkg.sv
// Purpose: types and shared decode function of the opcode field decoder
// Assumes: constants come from the header
// Notes: class codes are plain binary, states are one-hot
package iofd_pkg;
`include "iofd_consts.svh"

	typedef enum logic [4:0] {
		CL_OTHER = 5'h00, CL_SET_COND = 5'h01, CL_DEC_BRANCH = 5'h02, CL_COND_TRAP = 5'h03,
		CL_QUICK_SUB = 5'h04, CL_COND_BRANCH = 5'h05, CL_UNCOND_BRANCH = 5'h06,
		CL_SUBR_BRANCH = 5'h07, CL_QUICK_MOVE = 5'h08, CL_LOGIC_OR = 5'h09, CL_DIV_U = 5'h0a,
		CL_DIV_S = 5'h0b, CL_DEC_SUB = 5'h0c, CL_SUB = 5'h0d, CL_SUB_ADDR = 5'h0e,
		CL_EXT_SUB = 5'h0f, CL_CMP = 5'h10, CL_CMP_ADDR = 5'h11, CL_LOGIC_XOR = 5'h12,
		CL_MEM_CMP = 5'h13, CL_LOGIC_AND = 5'h14
	} iofd_class_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_DEC = 4'b0010,
		ST_EXT = 4'b0100,
		ST_OUT = 4'b1000
	} iofd_state_t;

	// Two-bit size field; the fourth code is not a size
	function automatic logic [1:0] iofd_size(input logic [1:0] code);
		iofd_size = (code == `IOFD_SZ_NONE) ? `IOFD_SZ_NONE : code;
	endfunction
endpackage

// ===== rtl/iofd_field_dec.sv
// Purpose: classify one opcode word and register its fields
// Assumes: load is a one-cycle pulse on the same clock
// Notes: outputs hold until the next load
module iofd_field_dec
	import iofd_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic load, // Capture op_word this edge
	input wire logic [15:0] op_word, // Opcode word
	output iofd_class_t cls_q, // Instruction class
	output logic [1:0] size_q, // Operand size code
	output logic [3:0] quick_q, // Quick subtract value 1..8
	output logic [1:0] ext_cnt_q, // Extension words to fetch
	output logic [31:0] imm_q, // Quick move value
	output logic [2:0] rx_q, // Register field 11:9
	output logic [2:0] ry_q, // Register field 2:0
	output logic regs_addr_q, // Both fields name address registers
	output logic predec_q, // Operands use predecrement addressing
	output logic mem_form_q, // Memory to memory form
	output logic [3:0] cond_q // Condition field
);
`include "iofd_consts.svh"
	iofd_class_t cls_d;
	logic [1:0] size_d, ext_cnt_d;
	logic [3:0] quick_d;
	logic [31:0] imm_d;
	logic regs_addr_d, predec_d, mem_form_d;

	always_comb begin
		cls_d = CL_OTHER;
		size_d = `IOFD_SZ_NONE;
		quick_d = 4'h0;
		ext_cnt_d = 2'h0;
		imm_d = 32'h0000_0000;
		regs_addr_d = 1'b0;
		predec_d = 1'b0;
		mem_form_d = 1'b0;
		case (op_word[15:12])
			`IOFD_GRP_QUICK: begin
				if (op_word[7:6] == 2'h3) begin
					if (op_word[5:3] == `IOFD_EA_AREG) begin
						cls_d = CL_DEC_BRANCH;
						ext_cnt_d = 2'h1;
					end else if (op_word[5:3] == `IOFD_EA_SPECIAL && op_word[2:0] == `IOFD_TRAP_WORD) begin
						cls_d = CL_COND_TRAP;
						ext_cnt_d = 2'h1;
						size_d = `IOFD_SZ_WORD;
					end else if (op_word[5:3] == `IOFD_EA_SPECIAL && op_word[2:0] == `IOFD_TRAP_LONG) begin
						cls_d = CL_COND_TRAP;
						ext_cnt_d = 2'h2;
						size_d = `IOFD_SZ_LONG;
					end else if (op_word[5:3] == `IOFD_EA_SPECIAL && op_word[2:0] == `IOFD_TRAP_NONE) begin
						cls_d = CL_COND_TRAP;
					end else begin
						cls_d = CL_SET_COND;
						size_d = `IOFD_SZ_BYTE;
					end
				end else if (op_word[8]) begin
					cls_d = CL_QUICK_SUB;
					size_d = iofd_size(op_word[7:6]);
					quick_d = (op_word[11:9] == 3'h0) ? `IOFD_QUICK_EIGHT : {1'b0, op_word[11:9]};
				end
			end
			`IOFD_GRP_BRANCH: begin
				if (op_word[11:8] == `IOFD_COND_TRUE)
					cls_d = CL_UNCOND_BRANCH;
				else if (op_word[11:8] == `IOFD_COND_SUBR)
					cls_d = CL_SUBR_BRANCH;
				else
					cls_d = CL_COND_BRANCH;
				if (op_word[7:0] == `IOFD_DISP_WORD)
					ext_cnt_d = 2'h1;
				else if (op_word[7:0] == `IOFD_DISP_LONG)
					ext_cnt_d = 2'h2;
			end
			`IOFD_GRP_QMOVE: begin
				if (!op_word[8]) begin
					cls_d = CL_QUICK_MOVE;
					size_d = `IOFD_SZ_LONG;
					imm_d = {{24{op_word[7]}}, op_word[7:0]};
				end
			end
			`IOFD_GRP_OR: begin
				if (op_word[8:6] == `IOFD_OPM_DIVU) begin
					cls_d = CL_DIV_U;
					size_d = `IOFD_SZ_WORD;
				end else if (op_word[8:6] == `IOFD_OPM_DIVS) begin
					cls_d = CL_DIV_S;
					size_d = `IOFD_SZ_WORD;
				end else if (op_word[8:4] == `IOFD_DSUB_FORM) begin
					cls_d = CL_DEC_SUB;
					size_d = `IOFD_SZ_BYTE;
					mem_form_d = op_word[3];
					regs_addr_d = op_word[3];
					predec_d = op_word[3];
				end else begin
					cls_d = CL_LOGIC_OR;
					size_d = iofd_size(op_word[7:6]);
				end
			end
			`IOFD_GRP_SUB: begin
				if (op_word[7:6] == 2'h3) begin
					cls_d = CL_SUB_ADDR;
					size_d = op_word[8] ? `IOFD_SZ_LONG : `IOFD_SZ_WORD;
				end else if (op_word[8] && op_word[5:4] == 2'h0) begin
					cls_d = CL_EXT_SUB;
					size_d = iofd_size(op_word[7:6]);
					mem_form_d = op_word[3];
					regs_addr_d = op_word[3];
					predec_d = op_word[3];
				end else begin
					cls_d = CL_SUB;
					size_d = iofd_size(op_word[7:6]);
				end
			end
			`IOFD_GRP_CMP: begin
				if (op_word[7:6] == 2'h3) begin
					cls_d = CL_CMP_ADDR;
					size_d = op_word[8] ? `IOFD_SZ_LONG : `IOFD_SZ_WORD;
				end else if (!op_word[8]) begin
					cls_d = CL_CMP;
					size_d = iofd_size(op_word[7:6]);
				end else if (op_word[5:3] == `IOFD_EA_AREG) begin
					cls_d = CL_MEM_CMP;
					size_d = iofd_size(op_word[7:6]);
					mem_form_d = 1'b1;
					regs_addr_d = 1'b1;
				end else begin
					cls_d = CL_LOGIC_XOR;
					size_d = iofd_size(op_word[7:6]);
				end
			end
			`IOFD_GRP_AND: begin
				// Opmodes 011/111 and bit 8 with mode 00x belong to other groups
				if (op_word[7:6] != 2'h3 && !(op_word[8] && op_word[5:4] == 2'h0)) begin
					cls_d = CL_LOGIC_AND;
					size_d = iofd_size(op_word[7:6]);
				end
			end
			default: begin
				cls_d = CL_OTHER;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cls_q <= CL_OTHER;
			size_q <= `IOFD_SZ_NONE;
			quick_q <= 4'h0;
			ext_cnt_q <= 2'h0;
			imm_q <= 32'h0000_0000;
			rx_q <= 3'h0;
			ry_q <= 3'h0;
			regs_addr_q <= 1'b0;
			predec_q <= 1'b0;
			mem_form_q <= 1'b0;
			cond_q <= 4'h0;
		end else if (load) begin
			cls_q <= cls_d;
			size_q <= size_d;
			quick_q <= quick_d;
			ext_cnt_q <= ext_cnt_d;
			imm_q <= imm_d;
			rx_q <= op_word[11:9];
			ry_q <= op_word[2:0];
			regs_addr_q <= regs_addr_d;
			predec_q <= predec_d;
			mem_form_q <= mem_form_d;
			cond_q <= op_word[11:8];
		end
	end
endmodule

// ===== rtl/iofd_top.sv
// Purpose: opcode field decoder between prefetch queue and sequencer
// Assumes: prefetch and sequencer run on aclk; AXI4-Lite register access
// Notes: effective-address extension words are left to the sequencer
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module iofd_top
	import iofd_pkg::*;
(
	input wire logic aclk, // System clock, 250 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic pf_valid, // Prefetch word available
	input wire logic [15:0] pf_word, // Prefetch word
	output logic pf_ready, // Decoder takes the word
	output logic dec_valid, // Decoded instruction available
	input wire logic dec_ready, // Sequencer takes it
	output iofd_class_t dec_class, // Instruction class
	output logic [15:0] dec_opword, // Opcode word
	output logic [1:0] dec_size, // Operand size code
	output logic [3:0] dec_quick, // Quick subtract value
	output logic [31:0] dec_imm, // Quick move value
	output logic [31:0] dec_ext, // Extension words, last in low half
	output logic [1:0] dec_ext_cnt, // Extension words held
	output logic [2:0] dec_rx, // Register field 11:9
	output logic [2:0] dec_ry, // Register field 2:0
	output logic dec_regs_addr, // Register fields name address registers
	output logic dec_predec, // Predecrement addressing
	output logic dec_mem_form, // Memory to memory form
	output logic [3:0] dec_cond, // Condition field
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
`include "iofd_consts.svh"

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	iofd_state_t state_q, state_d;
	logic [15:0] opword_q, opword_d;
	logic [31:0] ext_q, ext_d;
	logic [1:0] got_q, got_d;
	logic [31:0] count_q, count_d;
	logic [31:0] ctrl_q, ctrl_d;
	logic aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic load;
	logic word_take;
	logic do_write;
	logic clr_count;
	logic [1:0] need_cnt;
	iofd_class_t cls;
	logic [1:0] size;
	logic [3:0] quick;
	logic [31:0] imm;
	logic [2:0] rx, ry;
	logic regs_addr, predec, mem_form;
	logic [3:0] cond;

	function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = nw[i*8 +: 8];
		end
		strobe_merge = res;
	endfunction

	function automatic logic addr_known(input logic [7:0] a);
		addr_known = (a == `IOFD_REG_CTRL) || (a == `IOFD_REG_STATUS) || (a == `IOFD_REG_OPWORD) ||
			(a == `IOFD_REG_EXT) || (a == `IOFD_REG_IMM) || (a == `IOFD_REG_COUNT);
	endfunction

	// ----------------------------------------------------------------
	// Field decoder
	// ----------------------------------------------------------------
	iofd_field_dec u_dec (
		.aclk(aclk),
		.aresetn(aresetn),
		.load(load),
		.op_word(pf_word),
		.cls_q(cls),
		.size_q(size),
		.quick_q(quick),
		.ext_cnt_q(need_cnt),
		.imm_q(imm),
		.rx_q(rx),
		.ry_q(ry),
		.regs_addr_q(regs_addr),
		.predec_q(predec),
		.mem_form_q(mem_form),
		.cond_q(cond)
	);

	// ----------------------------------------------------------------
	// Fetch sequence
	// ----------------------------------------------------------------
	// Decoding stops between instructions only, so disabling never splits one
	assign pf_ready = ((state_q == ST_IDLE) && ctrl_q[`IOFD_CTRL_EN_BIT]) || (state_q == ST_EXT);
	assign word_take = pf_valid && pf_ready;
	assign load = word_take && (state_q == ST_IDLE);
	assign dec_valid = (state_q == ST_OUT);

	always_comb begin
		state_d = state_q;
		opword_d = opword_q;
		ext_d = ext_q;
		got_d = got_q;
		count_d = count_q;
		case (state_q)
			ST_IDLE: begin
				if (load) begin
					opword_d = pf_word;
					ext_d = 32'h0000_0000;
					got_d = 2'h0;
					state_d = ST_DEC;
				end
			end
			ST_DEC: begin
				state_d = (need_cnt == 2'h0) ? ST_OUT : ST_EXT;
			end
			ST_EXT: begin
				if (word_take) begin
					// Long operands arrive high word first
					ext_d = {ext_q[15:0], pf_word};
					got_d = got_q + 2'h1;
					if (got_q + 2'h1 == need_cnt)
						state_d = ST_OUT;
				end
			end
			ST_OUT: begin
				if (dec_ready) begin
					state_d = ST_IDLE;
					count_d = count_q + 32'h1;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (clr_count)
			count_d = 32'h0000_0000;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ST_IDLE;
			opword_q <= 16'h0000;
			ext_q <= 32'h0000_0000;
			got_q <= 2'h0;
			count_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			opword_q <= opword_d;
			ext_q <= ext_d;
			got_q <= got_d;
			count_q <= count_d;
		end
	end

	assign dec_class = cls;
	assign dec_opword = opword_q;
	assign dec_size = size;
	assign dec_quick = quick;
	assign dec_imm = imm;
	assign dec_ext = ext_q;
	assign dec_ext_cnt = got_q;
	assign dec_rx = rx;
	assign dec_ry = ry;
	assign dec_regs_addr = regs_addr;
	assign dec_predec = predec;
	assign dec_mem_form = mem_form;
	assign dec_cond = cond;

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign do_write = aw_held_q && w_held_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	// Clear bit is a self-clearing command, not stored
	assign clr_count = do_write && (awaddr_q == `IOFD_REG_CTRL) && wstrb_q[0] && wdata_q[`IOFD_CTRL_CLR_BIT];

	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = addr_known(awaddr_q) ? `IOFD_RESP_OKAY : `IOFD_RESP_SLVERR;
			if (awaddr_q == `IOFD_REG_CTRL)
				ctrl_d = strobe_merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0001;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `IOFD_RESP_OKAY;
			ctrl_q <= `IOFD_CTRL_RESET;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	always_comb begin
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = `IOFD_RESP_OKAY;
			case (s_axi_araddr)
				`IOFD_REG_CTRL: rdata_d = ctrl_q;
				`IOFD_REG_STATUS: rdata_d = {14'h0000, cls, mem_form, predec, regs_addr, size,
					got_q, need_cnt, state_q};
				`IOFD_REG_OPWORD: rdata_d = {4'h0, cond, 1'b0, rx, 1'b0, ry, opword_q};
				`IOFD_REG_EXT: rdata_d = ext_q;
				`IOFD_REG_IMM: rdata_d = (cls == CL_QUICK_SUB) ? {28'h0000000, quick} : imm;
				`IOFD_REG_COUNT: rdata_d = count_q;
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = `IOFD_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q <= `IOFD_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end
endmodule

// ===== dv/iofd_checker_sva.sv
// Purpose: port checks of the opcode field decoder
// Assumes: bound to iofd_top, single clock
// Notes: field checks apply while a decode is offered
module iofd_checker
	import iofd_pkg::*;
(
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic pf_ready, // Decoder takes a word
	input wire logic dec_valid, // Decode offered
	input wire logic dec_ready, // Sequencer takes it
	input wire iofd_class_t dec_class, // Class
	input wire logic [15:0] dec_opword, // Opcode word
	input wire logic [1:0] dec_size, // Size code
	input wire logic [3:0] dec_quick, // Quick value
	input wire logic [31:0] dec_imm, // Quick move value
	input wire logic [1:0] dec_ext_cnt, // Extension words
	input wire logic dec_regs_addr, // Address registers
	input wire logic dec_predec, // Predecrement
	input wire logic dec_mem_form // Memory form
);
	logic xsub;
	logic sized;
	logic branch;

	assign xsub = dec_valid && (dec_class == CL_DEC_SUB || dec_class == CL_EXT_SUB);
	assign sized = dec_valid && (dec_class == CL_QUICK_SUB || dec_class == CL_EXT_SUB || dec_class == CL_MEM_CMP);
	assign branch = dec_valid && (dec_class inside {CL_COND_BRANCH, CL_UNCOND_BRANCH, CL_SUBR_BRANCH});

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_trap_ext;
		dec_valid && dec_class == CL_COND_TRAP |->
			dec_ext_cnt == (dec_opword[2:0] == 3'h2 ? 2'h1 : (dec_opword[2:0] == 3'h3 ? 2'h2 : 2'h0));
	endproperty
	a_trap_ext: assert property (p_trap_ext) else $error("trap operand count wrong");
	property p_quick;
		dec_valid && dec_class == CL_QUICK_SUB |->
			dec_quick == (dec_opword[11:9] == 3'h0 ? 4'h8 : {1'b0, dec_opword[11:9]});
	endproperty
	a_quick: assert property (p_quick) else $error("quick value wrong");
	property p_size;
		sized |-> dec_size == dec_opword[7:6];
	endproperty
	a_size: assert property (p_size) else $error("size code wrong");
	property p_imm;
		dec_valid && dec_class == CL_QUICK_MOVE |-> dec_imm == {{24{dec_opword[7]}}, dec_opword[7:0]};
	endproperty
	a_imm: assert property (p_imm) else $error("quick move value wrong");
	property p_form;
		xsub |-> dec_mem_form == dec_opword[3];
	endproperty
	a_form: assert property (p_form) else $error("form bit wrong");
	property p_dreg;
		xsub && !dec_opword[3] |-> !dec_regs_addr && !dec_predec;
	endproperty
	a_dreg: assert property (p_dreg) else $error("register form wrong");
	property p_areg;
		xsub && dec_opword[3] |-> dec_regs_addr && dec_predec;
	endproperty
	a_areg: assert property (p_areg) else $error("memory form wrong");
	property p_branch_ext;
		branch |-> dec_ext_cnt == (dec_opword[7:0] == 8'h00 ? 2'h1 : (dec_opword[7:0] == 8'hff ? 2'h2 : 2'h0));
	endproperty
	a_branch_ext: assert property (p_branch_ext) else $error("displacement count wrong");
	// Sequencer may stall; the decode must not move under it
	property p_hold;
		dec_valid && !dec_ready |=> dec_valid && $stable(dec_opword) && $stable(dec_class);
	endproperty
	a_hold: assert property (p_hold) else $error("decode dropped while stalled");
	property p_refuse;
		dec_valid |-> !pf_ready ##1 (dec_valid || $past(dec_ready));
	endproperty
	a_refuse: assert property (p_refuse) else $error("word taken while decode pending");
endmodule

bind iofd_top iofd_checker i_chk (.aclk, .aresetn, .pf_ready, .dec_valid, .dec_ready, .dec_class, .dec_opword,
	.dec_size, .dec_quick, .dec_imm, .dec_ext_cnt, .dec_regs_addr, .dec_predec, .dec_mem_form);

// ===== dv/iofd_pf_model.sv
// Purpose: prefetch queue model feeding opcode and extension words
// Assumes: words are pushed between clock edges
// Notes: slow puts one idle cycle before each word
module iofd_pf_model (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic slow, // Idle cycle between words
	input wire logic pf_ready, // Decoder takes the word
	output logic pf_valid, // Word offered
	output logic [15:0] pf_word // Word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] q[$];
	logic gap_q;

	function automatic void push(input logic [15:0] w);
		q.push_back(w);
	endfunction

	initial pf_valid = 1'b0;

	// Idle word is scrambled so a stale value never passes for data
	always @(posedge aclk) begin
		if (!aresetn) begin
			pf_valid <= 1'b0;
			pf_word <= 16'h5a5a;
			gap_q <= 1'b0;
		end else if (pf_valid && !pf_ready) begin
			gap_q <= 1'b0;
		end else if (q.size() > 0 && (!slow || gap_q)) begin
			pf_valid <= 1'b1;
			pf_word <= q.pop_front();
			gap_q <= 1'b0;
		end else begin
			pf_valid <= 1'b0;
			pf_word <= ~pf_word;
			gap_q <= 1'b1;
		end
	end
endmodule

// ===== dv/integer_opcode_field_decoder_test.sv
// Purpose: self-checking bench of the opcode field decoder
// Assumes: prefetch model feeds words, the bench is the sequencer
// Notes: registers reached through AXI4-Lite tasks
module integer_opcode_field_decoder_test
	import iofd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 17;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic slow = 1'b0;
	logic dec_ready = 1'b0;
	logic pf_valid, pf_ready, dec_valid, dec_regs_addr, dec_predec, dec_mem_form;
	logic awready, wready, bvalid, arready, rvalid;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [3:0] wstrb = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [15:0] pf_word, dec_opword;
	iofd_class_t dec_class;
	logic [1:0] dec_size, dec_ext_cnt, bresp, rresp;
	logic [3:0] dec_quick, dec_cond;
	logic [31:0] dec_imm, dec_ext, rdata;
	logic [2:0] dec_rx, dec_ry;
	int mismatches = 0;
	int total_checks = 0;
	logic [15:0] ops [N] = '{16'h6000, 16'h61ff, 16'h6712, 16'h50fa, 16'h50fb, 16'h50fc, 16'h5180, 16'h5f00,
		16'h5740, 16'h7e80, 16'h707f, 16'h8109, 16'h8300, 16'h9388, 16'h9140, 16'hb308, 16'hb548};
	iofd_class_t cls [N] = '{CL_UNCOND_BRANCH, CL_SUBR_BRANCH, CL_COND_BRANCH, CL_COND_TRAP, CL_COND_TRAP,
		CL_COND_TRAP, CL_QUICK_SUB, CL_QUICK_SUB, CL_QUICK_SUB, CL_QUICK_MOVE, CL_QUICK_MOVE, CL_DEC_SUB,
		CL_DEC_SUB, CL_EXT_SUB, CL_EXT_SUB, CL_MEM_CMP, CL_MEM_CMP};
	logic [1:0] nx [N] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
		2'h0, 2'h0, 2'h0};

	always #2 aclk = ~aclk;

	iofd_top i_dut (.aclk(aclk), .aresetn(aresetn), .pf_valid(pf_valid), .pf_word(pf_word), .pf_ready(pf_ready),
		.dec_valid(dec_valid), .dec_ready(dec_ready), .dec_class(dec_class), .dec_opword(dec_opword),
		.dec_size(dec_size), .dec_quick(dec_quick), .dec_imm(dec_imm), .dec_ext(dec_ext),
		.dec_ext_cnt(dec_ext_cnt), .dec_rx(dec_rx), .dec_ry(dec_ry), .dec_regs_addr(dec_regs_addr),
		.dec_predec(dec_predec), .dec_mem_form(dec_mem_form), .dec_cond(dec_cond), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	iofd_pf_model i_pf (.aclk(aclk), .aresetn(aresetn), .slow(slow), .pf_ready(pf_ready), .pf_valid(pf_valid),
		.pf_word(pf_word));

	// ------------
	// Tasks
	// ------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic ta, tw;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end while ((awvalid && !ta) || (wvalid && !tw));
		do @(negedge aclk); while (bvalid !== 1'b1);
		chk(bresp, er, "bresp");
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		chk(rdata, ed, "rdata");
		chk(rresp, er, "rresp");
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	// Sequencer side: stalls two cycles before taking each decode
	task automatic get(input logic [15:0] op, input iofd_class_t c, input logic [1:0] n);
		for (int i = 0; i < 40 && dec_valid !== 1'b1; i++)
			@(negedge aclk);
		chk(dec_valid, 1'b1, "valid");
		chk(dec_opword, op, "opword");
		chk(dec_class, c, "class");
		chk(dec_ext_cnt, n, "ext count");
		chk(dec_cond, op[11:8], "cond");
		if (n == 2'h1)
			chk(dec_ext, 32'h0000_1234, "ext word");
		if (n == 2'h2)
			chk(dec_ext, 32'h1234_abcd, "ext long");
		if (c == CL_QUICK_SUB)
			chk(dec_quick, (op[11:9] == 3'h0) ? 4'h8 : {1'b0, op[11:9]}, "quick");
		if (c == CL_QUICK_SUB || c == CL_EXT_SUB || c == CL_MEM_CMP)
			chk(dec_size, op[7:6], "size");
		if (c == CL_QUICK_MOVE)
			chk(dec_imm, {{24{op[7]}}, op[7:0]}, "imm");
		if (c == CL_DEC_SUB || c == CL_EXT_SUB) begin
			chk(dec_mem_form, op[3], "form");
			chk({dec_regs_addr, dec_predec}, {2{op[3]}}, "regs");
			chk({dec_rx, dec_ry}, {op[11:9], op[2:0]}, "fields");
		end
		repeat (2) @(posedge aclk);
		dec_ready <= 1'b1;
		@(posedge aclk);
		dec_ready <= 1'b0;
	endtask

	task automatic issue(input logic [15:0] op, input iofd_class_t c, input logic [1:0] n);
		@(negedge aclk);
		i_pf.push(op);
		if (n > 2'h0)
			i_pf.push(16'h1234);
		if (n > 2'h1)
			i_pf.push(16'habcd);
		get(op, c, n);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------
	// Sequence
	// ------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(8'h00, 32'h1, 2'h0);
		axi_rd(8'h14, 32'h0, 2'h0);
		axi_rd(8'h40, 32'h0, 2'h2);
		axi_wr(8'h00, 32'h0, 4'h0, 2'h0);
		axi_rd(8'h00, 32'h1, 2'h0);
		for (int k = 0; k < N; k++) begin
			slow <= k[0];
			issue(ops[k], cls[k], nx[k]);
		end
		axi_rd(8'h14, N, 2'h0);
		axi_wr(8'h00, 32'h3, 4'hf, 2'h0);
		axi_rd(8'h14, 32'h0, 2'h0);
		// Disabled decoder must leave the word waiting
		axi_wr(8'h00, 32'h0, 4'hf, 2'h0);
		@(negedge aclk);
		i_pf.push(16'h7001);
		repeat (6) @(negedge aclk);
		chk({pf_valid, pf_ready, dec_valid}, 3'b100, "refused");
		axi_wr(8'h00, 32'h1, 4'hf, 2'h0);
		get(16'h7001, CL_QUICK_MOVE, 2'h0);
		axi_rd(8'h04, 32'h0001_0201, 2'h0);
		axi_rd(8'h08, 32'h0001_7001, 2'h0);
		axi_rd(8'h10, 32'h0000_0001, 2'h0);
		axi_wr(8'h30, 32'h1, 4'hf, 2'h2);
		wrap_up();
	end

	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end
endmodule
